// [logic/wws_defs.svh]
/*
 * constants of the window supervisor: timing figures, derived cycle counts,
 * failure counter steps and the limit of failed init phases.
 * assumes a 40 MHz system clock; included by bare name.
 */
`ifndef WWS_DEFS_SVH
`define WWS_DEFS_SVH

`define WWS_CLK_HZ          40000000
`define WWS_TICK_US         100
`define WWS_TICK_CYC        ((`WWS_CLK_HZ / 1000000) * `WWS_TICK_US)
`define WWS_SAMPLE_US       200
`define WWS_SAMPLE_TICKS    (`WWS_SAMPLE_US / `WWS_TICK_US)
`define WWS_LONG_OPEN_MS    600
`define WWS_LONG_OPEN_TICKS (`WWS_LONG_OPEN_MS * 1000 / `WWS_TICK_US)
`define WWS_WAKE_SHORT_MS   60
`define WWS_WAKE_SHORT_TICKS (`WWS_WAKE_SHORT_MS * 1000 / `WWS_TICK_US)
`define WWS_CYC_LONG_TICKS  10
`define WWS_CYC_SHORT_TICKS 1
`define WWS_FAIL_STEP_UP    2
`define WWS_FAIL_STEP_DOWN  1
`define WWS_MAX_INIT_FAILS  3

`endif

// [logic/wws_pin_sampler.sv]
/*
 * samples trigger_pin every sample period and flags a valid falling edge:
 * two high samples then two low samples, reported at the second low one.
 * assumes the pin is synchronous to sys_clk_in and sample_en_in pulses once.
 */
`timescale 1ns/1ps
`include "wws_defs.svh"
module wws_pin_sampler (
    input  wire logic sys_clk_in,
    input  wire logic rst_in,
    input  wire logic clear_in,
    input  wire logic sample_en_in,
    input  wire logic trigger_pin_in,
    output logic      trigger_out
);
    logic [3:0] hist_q;

    // ****************************************************************
    // sample history, newest sample in bit 0
    // ****************************************************************
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hist_q <= 4'h0;
        end else if (clear_in) begin
            hist_q <= 4'h0;
        end else if (sample_en_in) begin
            hist_q <= {hist_q[2:0], trigger_pin_in};
        end
    end

    // one-cycle pulse at the second low sample; rising edges never match
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            trigger_out <= 1'b0;
        end else begin
            trigger_out <= sample_en_in && !clear_in
                && hist_q[2:0] == 3'b110 && !trigger_pin_in;
        end
    end
endmodule : wws_pin_sampler

// [logic/wws_pkg.sv]
/*
 * types of the window supervisor.
 * assumes wws_defs.svh is available for the constants.
 */
package wws_pkg;
    typedef enum logic [1:0] {
        WWS_ST_INIT,
        WWS_ST_NORMAL,
        WWS_ST_WAKE,
        WWS_ST_OTHER
    } wws_sys_state_e;

    typedef enum logic [1:0] {
        WWS_WIN_IDLE,
        WWS_WIN_LONG,
        WWS_WIN_CLOSED,
        WWS_WIN_OPEN
    } wws_window_e;

    // configuration as written by software
    typedef struct packed {
        logic       pin_select;        // 1: trigger_pin, 0: service command
        logic       cycle_time_select; // 1: long cycle, 0: short cycle
        logic [7:0] open_cycles;
        logic [7:0] closed_cycles;
        logic [7:0] fail_threshold;
    } wws_cfg_s;

    // events reported towards the safe-state logic
    typedef struct packed {
        logic valid;
        logic invalid;
        logic irq;
        logic soft_reset;
        logic hard_reset;
        logic fail_safe;
        logic overflow;
    } wws_event_s;
endpackage : wws_pkg

// [logic/wws_window_supervisor.sv]
/*
 * window supervisor: long open, closed and open windows, trigger judgement,
 * failure counter and init-phase escalation.
 * assumes synchronous inputs, service_command_reg_wr_in a one-cycle pulse, and that
 * the system state machine reacts to the reset and fail-safe requests.
 */
`timescale 1ns/1ps
`include "wws_defs.svh"
module wws_window_supervisor #(
    parameter int TICK_CYC   = `WWS_TICK_CYC,
    parameter int LONG_TICKS = `WWS_LONG_OPEN_TICKS
) (
    input  wire logic                   sys_clk_in,
    input  wire logic                   rst_in,
    input  wire logic                   sync_clear_in,
    input  wire logic                   enable_in,
    input  wire wws_pkg::wws_sys_state_e sys_state_in,
    input  wire logic                   mcu_reset_out_in,
    input  wire logic                   sleep_wake_in,
    input  wire logic                   init_timer_expired_in,
    input  wire logic                   trigger_pin_in,
    input  wire logic                   service_command_reg_wr_in,
    input  wire logic                   cfg_wr_in,
    input  wire wws_pkg::wws_cfg_s      cfg_in,
    output wws_pkg::wws_cfg_s           cfg_out,
    output wws_pkg::wws_window_e        window_out,
    output wws_pkg::wws_event_s         event_out,
    output logic [7:0]                  fail_count_out,
    output logic                        normal_allowed_out,
    output logic                        window_result_out
);
    import wws_pkg::*;

    localparam logic [7:0] STEP_UP   = 8'(`WWS_FAIL_STEP_UP);
    localparam logic [7:0] STEP_DOWN = 8'(`WWS_FAIL_STEP_DOWN);
    localparam int         TW        = 24;

    wws_cfg_s    cfg_q;
    wws_window_e win_q;
    logic [15:0] tick_cnt_q;
    logic        tick;
    logic [TW-1:0] win_cnt_q;
    logic [1:0]  samp_cnt_q;
    logic        samp_en;
    logic        pin_trig;
    logic        trig;
    logic        rose_q;
    logic        mcu_reset_prev_q;
    logic        long_invalid_q;
    logic [1:0]  init_fails_q;
    logic        clr;
    logic        cfg_ok;
    logic [7:0]  fail_q;
    logic        valid_ev;
    logic        invalid_ev;
    logic        win_end;
    wws_event_s  ev_q;

    // length of a window in ticks from cycle count and cycle time
    function automatic logic [TW-1:0] win_ticks(input logic [7:0] cyc,
                                                input logic       long_cyc);
        logic [TW-1:0] per;
        per = long_cyc ? TW'(`WWS_CYC_LONG_TICKS) : TW'(`WWS_CYC_SHORT_TICKS);
        win_ticks = TW'(cyc) * per;
    endfunction : win_ticks

    // saturating failure counter arithmetic
    function automatic logic [7:0] fail_next(input logic [7:0] f,
                                             input logic       up);
        logic [8:0] s;
        s = {1'b0, f} + {1'b0, STEP_UP};
        if (up) begin
            fail_next = s[8] ? 8'hff : s[7:0];
        end else begin
            fail_next = (f != 8'h00) ? f - STEP_DOWN : f;
        end
    endfunction : fail_next

    assign clr    = sync_clear_in || !enable_in;
    assign cfg_ok = sys_state_in == WWS_ST_INIT
        || sys_state_in == WWS_ST_NORMAL
        || sys_state_in == WWS_ST_WAKE;

    // ****************************************************************
    // prescaler: one tick per cycle-time unit, then sample enable
    // ****************************************************************
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tick_cnt_q <= 16'h0000;
        end else if (clr || tick) begin
            tick_cnt_q <= 16'h0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
        end
    end
    assign tick = tick_cnt_q == 16'(TICK_CYC - 1);

    // sample period is a whole number of ticks
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            samp_cnt_q <= 2'h0;
        end else if (clr) begin
            samp_cnt_q <= 2'h0;
        end else if (tick) begin
            samp_cnt_q <= samp_en ? 2'h0 : samp_cnt_q + 2'h1;
        end
    end
    assign samp_en = tick && samp_cnt_q == 2'(`WWS_SAMPLE_TICKS - 1);

    wws_pin_sampler u_sampler (
        .sys_clk_in     (sys_clk_in),
        .rst_in         (rst_in),
        .clear_in       (clr),
        .sample_en_in   (samp_en),
        .trigger_pin_in (trigger_pin_in),
        .trigger_out    (pin_trig)
    );

    // pin ignored entirely while service triggering is chosen
    assign trig = cfg_q.pin_select ? pin_trig
                                   : service_command_reg_wr_in;

    // ****************************************************************
    // configuration
    // ****************************************************************
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_q <= '{pin_select: 1'b0, cycle_time_select: 1'b1,
                       open_cycles: 8'h0a, closed_cycles: 8'h0a,
                       fail_threshold: 8'h09};
        end else if (sync_clear_in) begin
            cfg_q <= '{pin_select: 1'b0, cycle_time_select: 1'b1,
                       open_cycles: 8'h0a, closed_cycles: 8'h0a,
                       fail_threshold: 8'h09};
        end else if (cfg_wr_in && cfg_ok) begin
            cfg_q <= cfg_in;
        end
    end

    // activation on rising reset output in init
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mcu_reset_prev_q <= 1'b0;
        end else begin
            mcu_reset_prev_q <= mcu_reset_out_in;
        end
    end
    assign rose_q = mcu_reset_out_in && !mcu_reset_prev_q
        && sys_state_in == WWS_ST_INIT;

    // ****************************************************************
    // window state and window timer
    // ****************************************************************
    assign win_end = tick && win_cnt_q == TW'(1);
    assign valid_ev = trig && (win_q == WWS_WIN_LONG
        || win_q == WWS_WIN_OPEN);
    assign invalid_ev = (trig && win_q == WWS_WIN_CLOSED)
        || (win_end && win_q == WWS_WIN_OPEN && !trig);

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            win_q     <= WWS_WIN_IDLE;
            win_cnt_q <= '0;
        end else if (clr) begin
            win_q     <= WWS_WIN_IDLE;
            win_cnt_q <= '0;
        end else if (rose_q) begin
            win_q     <= WWS_WIN_LONG;
            win_cnt_q <= TW'(LONG_TICKS);
        end else if (sleep_wake_in) begin
            win_q     <= WWS_WIN_OPEN;
            win_cnt_q <= cfg_q.cycle_time_select ? TW'(LONG_TICKS)
                       : TW'(`WWS_WAKE_SHORT_TICKS);
        end else begin
            case (win_q)
                WWS_WIN_LONG: begin
                    if (cfg_wr_in && cfg_ok) begin
                        win_q     <= WWS_WIN_OPEN;
                        win_cnt_q <= win_ticks(cfg_in.open_cycles,
                                               cfg_in.cycle_time_select);
                    end else if (trig) begin
                        win_q     <= WWS_WIN_CLOSED;
                        win_cnt_q <= win_ticks(cfg_q.closed_cycles,
                                               cfg_q.cycle_time_select);
                    end else if (win_end) begin
                        win_q     <= WWS_WIN_IDLE; // await init timer
                        win_cnt_q <= '0;
                    end else if (tick) begin
                        win_cnt_q <= win_cnt_q - TW'(1);
                    end
                end
                WWS_WIN_CLOSED: begin
                    if (trig || win_end) begin
                        win_q     <= WWS_WIN_OPEN;
                        win_cnt_q <= win_ticks(cfg_q.open_cycles,
                                               cfg_q.cycle_time_select);
                    end else if (tick) begin
                        win_cnt_q <= win_cnt_q - TW'(1);
                    end
                end
                WWS_WIN_OPEN: begin
                    if (trig) begin
                        win_q     <= WWS_WIN_CLOSED;
                        win_cnt_q <= win_ticks(cfg_q.closed_cycles,
                                               cfg_q.cycle_time_select);
                    end else if (win_end) begin
                        win_cnt_q <= win_ticks(cfg_q.open_cycles,
                                               cfg_q.cycle_time_select);
                    end else if (tick) begin
                        win_cnt_q <= win_cnt_q - TW'(1);
                    end
                end
                default: begin
                    // idle: a soft reset drops the reset output, the next
                    // rising edge reopens the long window
                    win_cnt_q <= '0;
                end
            endcase
        end
    end

    // ****************************************************************
    // init-phase escalation
    // ****************************************************************
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            long_invalid_q <= 1'b0;
        end else if (clr || rose_q || (win_q == WWS_WIN_LONG
                     && (trig || (cfg_wr_in && cfg_ok)))) begin
            long_invalid_q <= 1'b0;
        end else if (win_q == WWS_WIN_LONG && win_end) begin
            long_invalid_q <= 1'b1;
        end else if (init_timer_expired_in) begin
            long_invalid_q <= 1'b0;
        end
    end

    // consecutive failed long windows; any valid trigger breaks the run
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            init_fails_q <= 2'h0;
        end else if (clr || valid_ev) begin
            init_fails_q <= 2'h0;
        end else if (init_timer_expired_in && long_invalid_q
                     && init_fails_q != 2'(`WWS_MAX_INIT_FAILS)) begin
            init_fails_q <= init_fails_q + 2'h1;
        end
    end

    // ****************************************************************
    // failure counter and event outputs
    // ****************************************************************
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            fail_q <= 8'h00;
        end else if (clr) begin
            fail_q <= 8'h00;
        end else if (invalid_ev) begin
            fail_q <= fail_next(fail_q, 1'b1);
        end else if (valid_ev && !(win_q == WWS_WIN_LONG && cfg_wr_in)) begin
            fail_q <= fail_next(fail_q, 1'b0);
        end
    end

    // registered one-cycle pulses, one cycle after the cause
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ev_q <= '0;
        end else if (clr) begin
            ev_q <= '0;
        end else begin
            ev_q.valid      <= valid_ev;
            ev_q.invalid    <= invalid_ev;
            ev_q.irq        <= invalid_ev || sleep_wake_in;
            ev_q.soft_reset <= init_timer_expired_in && long_invalid_q
                && init_fails_q == 2'h0;
            ev_q.hard_reset <= init_timer_expired_in && long_invalid_q
                && init_fails_q == 2'h1;
            ev_q.fail_safe  <= init_timer_expired_in && long_invalid_q
                && init_fails_q == 2'h2;
            ev_q.overflow   <= invalid_ev
                && fail_next(fail_q, 1'b1) > cfg_q.fail_threshold;
        end
    end

    // window result level: low after an invalid, high after a valid
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            window_result_out <= 1'b1;
        end else if (clr || valid_ev) begin
            window_result_out <= 1'b1;
        end else if (invalid_ev) begin
            window_result_out <= 1'b0;
        end
    end

    // normal state permitted after first valid trigger
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            normal_allowed_out <= 1'b0;
        end else if (clr || rose_q || sleep_wake_in) begin
            normal_allowed_out <= 1'b0;
        end else if (valid_ev) begin
            normal_allowed_out <= 1'b1;
        end
    end

    // registered copies of internal state
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_out        <= '0;
            window_out     <= WWS_WIN_IDLE;
            fail_count_out <= 8'h00;
        end else begin
            cfg_out        <= cfg_q;
            window_out     <= win_q;
            fail_count_out <= fail_q;
        end
    end
    assign event_out = ev_q;
endmodule : wws_window_supervisor

// [sim/tb_top.sv]
/*
 * self-checking bench of the window supervisor with a controller model.
 * assumes short tick (4 clocks) and long window (20 ticks) parameters.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    fail_count++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
    import wws_pkg::*;
    // ****************************************************************
    // signals, design and model
    // ****************************************************************
    localparam int TCK = 4;
    localparam int LNG = 20;
    logic clk = 0, rst = 1, clr = 0, en = 1, mrst = 0, wake = 0, iexp = 0;
    logic cwr = 0, pin, swr, nrm, res;
    wws_sys_state_e st = WWS_ST_INIT;
    wws_cfg_s cfg = '0, cfo;
    wws_window_e win;
    wws_event_s ev;
    logic [7:0] fc;
    logic [15:0] lf = 16'h2aca;
    int fail_count = 0, check_count = 0, m_fail = 0, d;
    int n_v = 0, n_i = 0, n_q = 0, esc[$];
    always #12.5 clk = ~clk;
    wws_window_supervisor #(.TICK_CYC(TCK), .LONG_TICKS(LNG)) i_dut (
        .sys_clk_in(clk), .rst_in(rst), .sync_clear_in(clr), .enable_in(en),
        .sys_state_in(st), .mcu_reset_out_in(mrst), .sleep_wake_in(wake),
        .init_timer_expired_in(iexp), .trigger_pin_in(pin),
        .service_command_reg_wr_in(swr), .cfg_wr_in(cwr), .cfg_in(cfg),
        .cfg_out(cfo), .window_out(win), .event_out(ev), .fail_count_out(fc),
        .normal_allowed_out(nrm), .window_result_out(res));
    wws_mcu_model i_mcu (.sys_clk_in(clk), .trigger_pin_out(pin),
        .service_wr_out(swr));
    // event tally; escalation pulses queued in arrival order
    always @(posedge clk) begin
        if (ev.valid === 1'b1) n_v++;
        if (ev.invalid === 1'b1) n_i++;
        if (ev.irq === 1'b1) n_q++;
        if (ev.soft_reset === 1'b1) esc.push_back(1);
        if (ev.hard_reset === 1'b1) esc.push_back(2);
        if (ev.fail_safe === 1'b1) esc.push_back(3);
    end
    // reference counter: up two saturating, down one floored at zero
    function automatic void m_step(input bit up);
        if (up) m_fail = (m_fail > 253) ? 255 : m_fail + 2;
        else if (m_fail > 0) m_fail--;
    endfunction : m_step
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic wait_win(input wws_window_e w);
        int k;
        k = 0;
        while (win !== w && k < 2000) begin
            @(posedge clk);
            k++;
        end
        `CHK("window", w, win)
    endtask : wait_win
    task automatic sclear();
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        tick(3);
    endtask : sclear
    task automatic mrise();
        @(posedge clk) mrst <= 1'b0;
        tick(2);
        @(posedge clk) mrst <= 1'b1;
    endtask : mrise
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    // hang guard well beyond the planned run
    initial begin
        #(25 * 40000);
        fail_count++;
        finish_test();
    end
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        tick(16);
        rst <= 1'b0;
        tick(3);
        `CHK("pin_select", 1'b0, cfo.pin_select)
        `CHK("open_cycles", 8'h0a, cfo.open_cycles)
        `CHK("win_reset", WWS_WIN_IDLE, win)
        $display("test reset done");
        mrise();
        wait_win(WWS_WIN_LONG);
        i_mcu.pin_pulse(20);
        tick(20);
        `CHK("pin_in_svc", 0, n_v)
        i_mcu.service_cmd();
        tick(3);
        `CHK("valid_long", 1, n_v)
        `CHK("normal", 1'b1, nrm)
        `CHK("closed", WWS_WIN_CLOSED, win)
        `CHK("fail_floor", m_fail[7:0], fc)
        i_mcu.service_cmd();
        tick(3);
        m_step(1);
        `CHK("closed_trig", 1, n_i)
        `CHK("irq", 1, n_q)
        `CHK("fail_up", m_fail[7:0], fc)
        `CHK("result", 1'b0, res)
        `CHK("reopen", WWS_WIN_OPEN, win)
        for (d = 0; n_i == 1 && d < 1000; d++) tick(1);
        m_step(1);
        `CHK("open_len", 1, d > 390 && d < 404)
        `CHK("fail_exp", m_fail[7:0], fc)
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        tick(20 + lf[5:0]);
        i_mcu.service_cmd();
        tick(3);
        m_step(0);
        `CHK("fail_down", m_fail[7:0], fc)
        `CHK("no_irq", 2, n_q)
        for (d = 0; win !== WWS_WIN_OPEN && d < 1000; d++) tick(1);
        `CHK("closed_len", 1, d > 390 && d < 404)
        `CHK("closed_end", 2, n_i)
        $display("test service windows done");
        sclear();
        `CHK("fail_clr", 8'h00, fc)
        mrise();
        wait_win(WWS_WIN_LONG);
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        // random overflow threshold reaches the design through cfg_in
        @(posedge clk) cfg <= '{1'b1, 1'b0, 8'h28, 8'h0c, lf[7:0]};
        cwr <= 1'b1;
        @(posedge clk) cwr <= 1'b0;
        wait_win(WWS_WIN_OPEN);
        `CHK("cfg", cfg, cfo)
        i_mcu.service_cmd();
        tick(4);
        `CHK("svc_in_pin", 2, n_v)
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        i_mcu.pin_pulse(17 + lf[2:0]);
        tick(24);
        `CHK("pin_valid", 3, n_v)
        i_mcu.pin_level(1'b1);
        tick(8);
        `CHK("rise_closed", 2, n_i)
        wait_win(WWS_WIN_OPEN);
        i_mcu.pin_level(1'b0);
        tick(24);
        `CHK("pin_straddle", 4, n_v)
        $display("test pin trigger done");
        sclear();
        for (int k = 1; k <= 3; k++) begin
            mrise();
            wait_win(WWS_WIN_LONG);
            tick(LNG * TCK + 6);
            `CHK("long_end", WWS_WIN_IDLE, win)
            @(posedge clk) iexp <= 1'b1;
            @(posedge clk) iexp <= 1'b0;
            tick(3);
            `CHK("escalate", k, esc.size() > 0 ? esc.pop_front() : 0)
        end
        `CHK("esc_no_irq", 2, n_q)
        $display("test escalation done");
        sclear();
        st <= WWS_ST_WAKE;
        @(posedge clk) wake <= 1'b1;
        @(posedge clk) wake <= 1'b0;
        tick(4);
        `CHK("wake_irq", 3, n_q)
        `CHK("wake_open", WWS_WIN_OPEN, win)
        @(posedge clk) en <= 1'b0;
        tick(3);
        `CHK("disabled", WWS_WIN_IDLE, win)
        $display("test wake and disable done");
        finish_test();
    end
endmodule : tb_top

// [sim/wws_assertions.sv]
/*
 * port checker of the window supervisor.
 * assumes the bind below onto wws_window_supervisor.
 */
`timescale 1ns/1ps
module wws_checker
    import wws_pkg::*;
#(
    parameter int TICK_CYC   = 4,
    parameter int LONG_TICKS = 20
) (
    input wire logic           sys_clk_in,
    input wire logic           rst_in,
    input wire logic           sync_clear_in,
    input wire logic           enable_in,
    input wire wws_sys_state_e sys_state_in,
    input wire logic           mcu_reset_out_in,
    input wire logic           service_command_reg_wr_in,
    input wire logic           cfg_wr_in,
    input wire wws_cfg_s       cfg_out,
    input wire wws_window_e    window_out,
    input wire wws_event_s     event_out,
    input wire logic [7:0]     fail_count_out,
    input wire logic           normal_allowed_out
);
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    int long_cnt_q;
    // length of the long window as seen at the port
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) long_cnt_q <= 0;
        else long_cnt_q <= (window_out == WWS_WIN_LONG) ? long_cnt_q + 1 : 0;
    end
    sequence s_closed; ##1 window_out == WWS_WIN_CLOSED; endsequence
    sequence s_open; ##1 window_out == WWS_WIN_OPEN; endsequence
    valid_no_irq_a: assert property (event_out.valid |-> !event_out.irq)
        else $error("irq on valid trigger");
    valid_closes_a: assert property (event_out.valid |-> s_closed)
        else $error("valid trigger did not close window");
    invalid_opens_a: assert property (event_out.invalid &&
        window_out inside {WWS_WIN_CLOSED, WWS_WIN_OPEN}
        |-> event_out.irq ##0 s_open) else $error("invalid not irq/open");
    svc_judged_a: assert property (service_command_reg_wr_in &&
        !cfg_out.pin_select && enable_in && !sync_clear_in && !cfg_wr_in &&
        window_out inside {WWS_WIN_CLOSED, WWS_WIN_OPEN}
        |-> ##1 (event_out.valid || event_out.invalid)) else $error("unjudged");
    pin_ignored_a: assert property (event_out.valid &&
        !$past(cfg_out.pin_select) && !$past(cfg_out.pin_select, 2)
        |-> $past(service_command_reg_wr_in)) else $error("pin not ignored");
    normal_valid_a: assert property ($rose(normal_allowed_out)
        |-> event_out.valid) else $error("normal allowed without trigger");
    fail_step_a: assert property ($changed(fail_count_out) |->
        fail_count_out == $past(fail_count_out) + 8'h02 || fail_count_out == 0
        || fail_count_out == $past(fail_count_out) - 8'h01)
        else $error("failure counter step wrong");
    clear_idle_a: assert property (sync_clear_in |-> ##2
        window_out == WWS_WIN_IDLE && fail_count_out == 8'h00)
        else $error("clear did not reinit");
    long_start_a: assert property ($rose(mcu_reset_out_in) && enable_in &&
        sys_state_in == WWS_ST_INIT && !sync_clear_in &&
        window_out == WWS_WIN_IDLE |-> ##[1:3] window_out == WWS_WIN_LONG)
        else $error("long window not opened");
    long_max_a: assert property (long_cnt_q <= LONG_TICKS * TICK_CYC + 4)
        else $error("long window too long");
endmodule : wws_checker

bind wws_window_supervisor wws_checker #(
    .TICK_CYC(TICK_CYC), .LONG_TICKS(LONG_TICKS)
) i_chk (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .sync_clear_in(sync_clear_in),
    .enable_in(enable_in), .sys_state_in(sys_state_in),
    .mcu_reset_out_in(mcu_reset_out_in), .cfg_wr_in(cfg_wr_in),
    .service_command_reg_wr_in(service_command_reg_wr_in),
    .cfg_out(cfg_out), .window_out(window_out), .event_out(event_out),
    .fail_count_out(fail_count_out), .normal_allowed_out(normal_allowed_out)
);

// [sim/wws_mcu_model.sv]
/*
 * monitored controller: drives trigger_pin and service command writes.
 * assumes the bench calls its tasks; pin idles low (pull-down).
 */
`timescale 1ns/1ps
module wws_mcu_model (
    input  wire logic sys_clk_in,
    output logic      trigger_pin_out,
    output logic      service_wr_out
);
    // ****************************************************************
    // driver tasks
    // ****************************************************************
    initial begin
        trigger_pin_out = 1'b0;
        service_wr_out = 1'b0;
    end
    // one-cycle service write, the only trigger while pin is ignored
    task automatic service_cmd();
        @(posedge sys_clk_in);
        service_wr_out <= 1'b1;
        @(posedge sys_clk_in);
        service_wr_out <= 1'b0;
    endtask : service_cmd
    // pin may rise in a closed window; only the fall counts
    task automatic pin_level(input logic lvl);
        @(posedge sys_clk_in);
        trigger_pin_out <= lvl;
    endtask : pin_level
    // high long enough for two samples, then low for good
    task automatic pin_pulse(input int hi);
        pin_level(1'b1);
        repeat (hi) @(posedge sys_clk_in);
        trigger_pin_out <= 1'b0;
    endtask : pin_pulse
endmodule : wws_mcu_model
